// File: hdl/ats_trigger_select.sv
/*
 * Conversion trigger source selector with its select register.
 * Assumes a byte register port with one-cycle strobes, event
 * inputs synchronous to CLK, and a converter that starts on
 * each START_CONV pulse.
 */
// Our own choice: strobed register access.
`timescale 1ns/1ns
// Overview of operation
// - Five-bit source code, cleared at reset
// - Code 11111: channel-select write triggers
// - Code 11110: result high-byte read triggers
// - Code 11101: error high-byte read triggers
// - Codes 11010 to 11100 reserved, no trigger
// - Codes 11001..10110: logic cells four..one
// - Code 10101: interrupt-on-change flag
// - Comparators two, one; oscillator codes
// - PWM units four and three outputs
module ats_trigger_select
    import ats_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic CHANNEL_SELECT_WRITE,
    input wire logic RESULT_HIGH_BYTE_READ,
    input wire logic SETPOINT_ERROR_HIGH_BYTE_READ,
    input wire logic LOGIC_CELL1_OUTPUT,
    input wire logic LOGIC_CELL2_OUTPUT,
    input wire logic LOGIC_CELL3_OUTPUT,
    input wire logic LOGIC_CELL4_OUTPUT,
    input wire logic IOC_FLAG,
    input wire logic COMPARATOR1_OUTPUT,
    input wire logic COMPARATOR2_OUTPUT,
    input wire logic OSCILLATOR_OUTPUT,
    input wire logic PWM_UNIT3_FIRST_OUTPUT,
    input wire logic PWM_UNIT3_SECOND_OUTPUT,
    input wire logic PWM_UNIT4_FIRST_OUTPUT,
    input wire logic PWM_UNIT4_SECOND_OUTPUT,
    input wire logic CAPTURE_COMPARE1_OUTPUT,
    input wire logic CAPTURE_COMPARE2_OUTPUT,
    output logic [4:0] TRIGGER_SOURCE_CODE,
    output logic START_CONV
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Select register
    // ------------------------------------------------------------
    logic [4:0] code_r;
    logic [7:0] rdata_r;
    logic hit;

    assign hit = (ADDR == ATS_TRIGGER_SELECT_ADDR);

    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            code_r <= ATS_TRIGGER_SELECT_RESET[ATS_CODE_MSB:0];
        end else if (WR && hit) begin
            code_r <= WDATA[ATS_CODE_MSB:0];
        end
    end

    // Upper bits unimplemented, read as zero
    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= ATS_UNMAPPED_READ;
        end else if (RD && hit) begin
            rdata_r <= {ATS_UPPER_ZERO, code_r};
        end else begin
            rdata_r <= ATS_UNMAPPED_READ;
        end
    end

    assign RDATA = rdata_r;
    assign TRIGGER_SOURCE_CODE = code_r;

    // ------------------------------------------------------------
    // Source table
    // ------------------------------------------------------------
    logic [ATS_NUM_SRC-1:0] src_vec;
    logic [ATS_NUM_SRC-1:0] src_valid;

    always_comb begin
        src_vec = '0;
        src_vec[ATS_SRC_CHAN_WRITE] = CHANNEL_SELECT_WRITE;
        src_vec[ATS_SRC_RESULT_READ] = RESULT_HIGH_BYTE_READ;
        src_vec[ATS_SRC_ERROR_READ] = SETPOINT_ERROR_HIGH_BYTE_READ;
        src_vec[ATS_SRC_CELL4] = LOGIC_CELL4_OUTPUT;
        src_vec[ATS_SRC_CELL3] = LOGIC_CELL3_OUTPUT;
        src_vec[ATS_SRC_CELL2] = LOGIC_CELL2_OUTPUT;
        src_vec[ATS_SRC_CELL1] = LOGIC_CELL1_OUTPUT;
        src_vec[ATS_SRC_IOC] = IOC_FLAG;
        src_vec[ATS_SRC_CMP2] = COMPARATOR2_OUTPUT;
        src_vec[ATS_SRC_CMP1] = COMPARATOR1_OUTPUT;
        src_vec[ATS_SRC_OSC] = OSCILLATOR_OUTPUT;
        src_vec[ATS_SRC_PWM4_B] = PWM_UNIT4_SECOND_OUTPUT;
        src_vec[ATS_SRC_PWM4_A] = PWM_UNIT4_FIRST_OUTPUT;
        src_vec[ATS_SRC_PWM3_B] = PWM_UNIT3_SECOND_OUTPUT;
        src_vec[ATS_SRC_PWM3_A] = PWM_UNIT3_FIRST_OUTPUT;
        src_vec[ATS_SRC_CCP2] = CAPTURE_COMPARE2_OUTPUT;
        src_vec[ATS_SRC_CCP1] = CAPTURE_COMPARE1_OUTPUT;
    end

    // Codes outside the table, reserved ones included, never fire
    genvar gi;
    generate
        for (gi = 0; gi < ATS_NUM_SRC; gi++) begin : g_valid
            localparam logic [4:0] CODE = 5'(gi);
            assign src_valid[gi] =
                !((CODE >= ATS_SRC_RSVD_LO) && (CODE <= ATS_SRC_RSVD_HI))
                && ((CODE >= ATS_SRC_CCP1 && CODE <= ATS_SRC_CCP2)
                || (CODE >= ATS_SRC_PWM3_A));
        end
    endgenerate

    // ------------------------------------------------------------
    // Trigger forming
    // ------------------------------------------------------------
    ats_sel_if sel ();

    assign sel.level = src_vec[code_r];
    assign sel.allowed = src_valid[code_r];

    ats_pulse u_pulse (
        .clk(CLK),
        .rst_n(rst_n_r),
        .sel(sel)
    );

    // Pulse held in a flip-flop so START_CONV is glitch free
    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            START_CONV <= 1'b0;
        end else begin
            START_CONV <= sel.pulse;
        end
    end
endmodule

// File: hdl/ats_pkg.sv
/*
 * Constants for the conversion trigger source selector.
 * Assumes a single 125 MHz system clock and byte-wide register port.
 */
package ats_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ATS_ADDR_W = 16;
    localparam logic [15:0] ATS_TRIGGER_SELECT_ADDR = 16'h1d2c;
    localparam logic [7:0] ATS_TRIGGER_SELECT_RESET = 8'h00;
    localparam int ATS_CODE_W = 5;
    localparam int ATS_CODE_MSB = 4;
    localparam logic [7:0] ATS_UNMAPPED_READ = 8'h00;
    localparam logic [2:0] ATS_UPPER_ZERO = 3'h0;
    localparam int ATS_NUM_SRC = 32;

    // ------------------------------------------------------------
    // Trigger source codes
    // ------------------------------------------------------------
    localparam logic [4:0] ATS_SRC_CHAN_WRITE = 5'h1f;
    localparam logic [4:0] ATS_SRC_RESULT_READ = 5'h1e;
    localparam logic [4:0] ATS_SRC_ERROR_READ = 5'h1d;
    localparam logic [4:0] ATS_SRC_RSVD_HI = 5'h1c;
    localparam logic [4:0] ATS_SRC_RSVD_LO = 5'h1a;
    localparam logic [4:0] ATS_SRC_CELL4 = 5'h19;
    localparam logic [4:0] ATS_SRC_CELL3 = 5'h18;
    localparam logic [4:0] ATS_SRC_CELL2 = 5'h17;
    localparam logic [4:0] ATS_SRC_CELL1 = 5'h16;
    localparam logic [4:0] ATS_SRC_IOC = 5'h15;
    localparam logic [4:0] ATS_SRC_CMP2 = 5'h14;
    localparam logic [4:0] ATS_SRC_CMP1 = 5'h13;
    localparam logic [4:0] ATS_SRC_OSC = 5'h12;
    localparam logic [4:0] ATS_SRC_PWM4_B = 5'h11;
    localparam logic [4:0] ATS_SRC_PWM4_A = 5'h10;
    localparam logic [4:0] ATS_SRC_PWM3_B = 5'h0f;
    localparam logic [4:0] ATS_SRC_PWM3_A = 5'h0e;
    localparam logic [4:0] ATS_SRC_CCP2 = 5'h0a;
    localparam logic [4:0] ATS_SRC_CCP1 = 5'h09;

    // ------------------------------------------------------------
    // Edge detector state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ATS_IDLE = 2'b00,
        ATS_FIRE = 2'b01,
        ATS_HOLD = 2'b11
    } ats_state_e;
endpackage

// File: hdl/ats_sel_if.sv
/*
 * Interface carrying the selected event level to the pulse former.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ns
interface ats_sel_if;
    logic level;
    logic allowed;
    logic pulse;
    modport src (output level, output allowed, input pulse);
    modport fmr (input level, input allowed, output pulse);
endinterface

// File: hdl/ats_pulse.sv
/*
 * Pulse former: one clock pulse per rising edge of the selected event.
 * Assumes the event level is synchronous to CLK.
 */
`timescale 1ns/1ns
module ats_pulse
    import ats_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    ats_sel_if.fmr sel
);
    ats_state_e state_r;
    ats_state_e state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ATS_IDLE: begin
                if (sel.level && sel.allowed) begin
                    state_nxt = ATS_FIRE;
                end
            end
            ATS_FIRE: begin
                state_nxt = sel.level ? ATS_HOLD : ATS_IDLE;
            end
            ATS_HOLD: begin
                if (!sel.level) begin
                    state_nxt = ATS_IDLE;
                end
            end
            default: begin
                state_nxt = ATS_IDLE;
            end
        endcase
    end

    // One start per event, held off until the level drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ATS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sel.pulse = (state_r == ATS_FIRE);
endmodule

// File: test/ats_trig_checker.sv
/* Port checks for the conversion trigger selector.
   Assumes one clock and the package register constants. */
`timescale 1ns/1ns
module ats_trig_checker
    import ats_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic CHANNEL_SELECT_WRITE,
    input wire logic [4:0] TRIGGER_SOURCE_CODE,
    input wire logic START_CONV
);
    // ------
    // Checks
    // ------
    logic [4:0] wd_r;
    logic sel;
    assign sel = ADDR == ATS_TRIGGER_SELECT_ADDR;
    always_ff @(posedge CLK) wd_r <= WDATA[4:0];
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    chk_code_reset: assert property ($rose(RESETN) |->
        (TRIGGER_SOURCE_CODE == 5'h00)[*3]) else $error("code not cleared");
    chk_code_write: assert property (WR && sel |=>
        TRIGGER_SOURCE_CODE == wd_r) else $error("code not loaded");
    chk_code_hold: assert property (!(WR && sel) |=>
        $stable(TRIGGER_SOURCE_CODE)) else $error("code changed");
    chk_read_data: assert property (RD && sel |=>
        RDATA == {3'h0, $past(TRIGGER_SOURCE_CODE)}) else $error("bad read");
    chk_read_other: assert property (!(RD && sel) |=>
        RDATA == 8'h00) else $error("read data not zero");
    chk_start_single: assert property (START_CONV |=>
        !START_CONV) else $error("start too long");
    chk_reserved_quiet: assert property (
        (TRIGGER_SOURCE_CODE inside {[5'h1a:5'h1c]})[*4] |-> !START_CONV)
        else $error("start on reserved code");
    chk_chan_fire: assert property (
        TRIGGER_SOURCE_CODE == 5'h1f && $rose(CHANNEL_SELECT_WRITE)
        |-> ##[2:3] START_CONV) else $error("no start on channel write");
endmodule
bind ats_trigger_select ats_trig_checker u_chk (.CLK(CLK), .RESETN(RESETN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CHANNEL_SELECT_WRITE(CHANNEL_SELECT_WRITE),
    .TRIGGER_SOURCE_CODE(TRIGGER_SOURCE_CODE), .START_CONV(START_CONV));

// File: test/ats_event_model.sv
/* Event sources and software strobes around the selector.
   Assumes requests are changed right after a rising clock edge. */
`timescale 1ns/1ns
module ats_event_model
(
    input wire logic clk,
    input wire logic go,
    input wire logic [16:0] mask,
    output logic [16:0] ev
);
    // ------------------
    // Registered events, high one cycle after go is high
    // ------------------
    always @(posedge clk) ev <= go ? mask : 17'h0;
endmodule

// File: test/testbench.sv
/* Register and trigger tests for the selector.
   Assumes the event model drives all event inputs. */
`timescale 1ns/1ns
module testbench;
    import ats_pkg::*;
    // -----
    // Bench
    // -----
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, go = 0, start;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic [4:0] code;
    logic [16:0] mask = 17'h0, ev;
    int err_count = 0, comparisons = 0, starts = 0, mark = 0;
    localparam logic [4:0] MAP [17] = '{5'h1f, 5'h1e, 5'h1d, 5'h16, 5'h17,
        5'h18, 5'h19, 5'h15, 5'h13, 5'h14, 5'h12, 5'h0e, 5'h0f, 5'h10, 5'h11,
        5'h09, 5'h0a};
    localparam logic [4:0] RSV [4] = '{5'h1a, 5'h1b, 5'h1c, 5'h00};
    ats_event_model src (.clk(clk), .go(go), .mask(mask), .ev(ev));
    ats_trigger_select dut (.CLK(clk), .RESETN(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CHANNEL_SELECT_WRITE(ev[0]), .RESULT_HIGH_BYTE_READ(ev[1]),
        .SETPOINT_ERROR_HIGH_BYTE_READ(ev[2]), .LOGIC_CELL1_OUTPUT(ev[3]),
        .LOGIC_CELL2_OUTPUT(ev[4]), .LOGIC_CELL3_OUTPUT(ev[5]),
        .LOGIC_CELL4_OUTPUT(ev[6]), .IOC_FLAG(ev[7]),
        .COMPARATOR1_OUTPUT(ev[8]), .COMPARATOR2_OUTPUT(ev[9]),
        .OSCILLATOR_OUTPUT(ev[10]), .PWM_UNIT3_FIRST_OUTPUT(ev[11]),
        .PWM_UNIT3_SECOND_OUTPUT(ev[12]), .PWM_UNIT4_FIRST_OUTPUT(ev[13]),
        .PWM_UNIT4_SECOND_OUTPUT(ev[14]), .CAPTURE_COMPARE1_OUTPUT(ev[15]),
        .CAPTURE_COMPARE2_OUTPUT(ev[16]), .TRIGGER_SOURCE_CODE(code),
        .START_CONV(start));
    initial forever #4 clk = ~clk;
    // Unknown start counts as a start
    always @(posedge clk) if (start !== 1'b0) starts++;
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic cmp_starts(input int want);
        comparisons++;
        if (starts - mark != want) begin
            err_count++;
            $display("unexpected at %0t: %0d starts want %0d", $time,
                starts - mark, want);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    // Events high for n cycles
    task automatic fire(input logic [16:0] m, input int n = 1);
        mark = starts;
        @(posedge clk);
        mask <= m;
        go <= 1'b1;
        repeat (n) @(posedge clk);
        go <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(ATS_TRIGGER_SELECT_ADDR, d);
        cmp(d, 8'h00);
        wr_reg(ATS_TRIGGER_SELECT_ADDR, 8'hff);
        rd_reg(ATS_TRIGGER_SELECT_ADDR, d);
        cmp(d, 8'h1f);
        wr_reg(16'h1d2d, 8'h05);
        rd_reg(16'h1d2d, d);
        cmp(d, 8'h00);
        cmp({3'h0, code}, 8'h1f);
        for (int i = 0; i < 17; i++) begin
            wr_reg(ATS_TRIGGER_SELECT_ADDR, {3'h0, MAP[i]});
            fire(~(17'h1 << i));
            cmp_starts(0);
            fire(17'h1 << i);
            cmp_starts(1);
        end
        // Level held for several cycles gives one start
        wr_reg(ATS_TRIGGER_SELECT_ADDR, {3'h0, ATS_SRC_CMP1});
        fire(17'h1 << 8, 5);
        cmp_starts(1);
        foreach (RSV[j]) begin
            wr_reg(ATS_TRIGGER_SELECT_ADDR, {3'h0, RSV[j]});
            fire(17'h1ffff);
            cmp_starts(0);
        end
        summarize();
    end
endmodule
